/* core/nfs_core.sv */
// Numerically controlled oscillator core with its byte-wide register file.
// Assumes a register master that drives one-cycle strobes and reads data a cycle later.
// Summary of operation
// - Twenty-bit accumulator readable and writable as low, high and upper-nibble bytes.
// - Each selected-clock rising edge adds the active increment into the accumulator.
// - The addition carry is the raw overflow driving output and flag.
// - Sixteen-bit increment in two byte registers backed by hidden buffers.
// - Enabled: low-byte write loads buffers on second following oscillator edge.
// - Disabled: any increment write loads the buffers immediately.
// - Two-bit source field picks fast oscillator, system clock, cell, pin.
// - Fixed-duty mode toggles the output on every overflow.
// - Control bit 0 chooses fixed-duty when clear, pulse mode when set.
// - Pulse mode drives output active from the edge after overflow.
// - Three-bit width code gives two to the code oscillator periods.
// - Width code matters only in pulse mode.
// - Final stage inverts the output when control bit 4 is set.
// - Polarity change with interrupts enabled raises the interrupt flag.
// - Read-only control bit 5 shows the final output level.
// - Control bit 6 connects the final output to its pin.
// - Control bit 7 runs the oscillator when set, stops it when clear.
// - Overflow sets the flag; request needs all four enables set.
// - Reset clears every register of the block to zero.
// - Runs in sleep while clocked; fast oscillator held when selected and on.
`timescale 1ns/10ps
module nfs_core
    import nfs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Register port.
    input wire nfs_bus_req_type bus_req,
    output logic [7:0] rd_data,
    // Accumulator clock sources.
    input wire logic fast_internal_osc,
    input wire logic logic_cell_one_out,
    input wire logic clock_pin,
    // Interrupt enables held outside the block.
    input wire logic peripheral_irq_on,
    input wire logic global_irq_on,
    // Synthesised output, its pin and the interrupt request.
    output logic synth_out,
    output logic synth_pin_out,
    output logic synth_pin_oe,
    output logic irq_req,
    // Keeps the fast oscillator running through sleep.
    output logic fast_osc_hold
);

    nfs_state_type st;
    nfs_state_type nx;
    logic tick;
    logic carry;
    logic [19:0] sum_low;
    logic [7:0] width_count;
    logic raw_level;
    logic ctl_write;
    logic clk_write;
    logic acc_write;
    logic step_low_write;
    logic step_write;

    // Adds the increment buffer to the accumulator, wrapping at twenty bits.
    function automatic logic [20:0] nfs_add(input logic [19:0] acc, input logic [15:0] step);
        nfs_add = {1'b0, acc} + {5'h00, step};
    endfunction

    // Active time in oscillator periods for a width code.
    function automatic logic [7:0] nfs_width(input logic [2:0] code);
        nfs_width = 8'h01 << code;
    endfunction

    // Output before the polarity stage for a given state.
    function automatic logic nfs_raw(input nfs_state_type s);
        if (s.pulse_mode_sel) begin
            nfs_raw = (s.pulse_state == NFS_PULSE_ACTIVE);
        end else begin
            nfs_raw = s.toggle;
        end
    endfunction

    // Tick source for the accumulator.
    nfs_tick_sel u_tick_sel (
        .clk(clk),
        .reset(reset),
        .source_sel(st.clock_source_sel),
        .enable(st.module_on),
        .fast_internal_osc(fast_internal_osc),
        .logic_cell_one_out(logic_cell_one_out),
        .clock_pin(clock_pin),
        .tick(tick)
    );

    // Address decode of write strobes.
    always_comb begin
        ctl_write = 1'b0;
        clk_write = 1'b0;
        acc_write = 1'b0;
        step_low_write = 1'b0;
        step_write = 1'b0;
        if (bus_req.wr && bus_req.addr == NFS_OFF_CONTROL) begin
            ctl_write = 1'b1;
        end else if (bus_req.wr && bus_req.addr == NFS_OFF_CLOCK_SELECT) begin
            clk_write = 1'b1;
        end else if (bus_req.wr && bus_req.addr >= NFS_OFF_ACC_LOW
                     && bus_req.addr <= NFS_OFF_ACC_UPPER) begin
            acc_write = 1'b1;
        end else if (bus_req.wr && bus_req.addr == NFS_OFF_STEP_LOW) begin
            step_low_write = 1'b1;
            step_write = 1'b1;
        end else if (bus_req.wr && bus_req.addr == NFS_OFF_STEP_HIGH) begin
            step_write = 1'b1;
        end
    end

    // Raw overflow of the addition and the pulse length for the current code.
    always_comb begin
        {carry, sum_low} = nfs_add(st.acc, st.step_buf);
        width_count = nfs_width(st.pulse_width_sel);
        raw_level = nfs_raw(st);
    end

    // Next-state logic: datapath on ticks, then software writes on top.
    always_comb begin
        nx = st;
        // Accumulator step and overflow handling on each oscillator tick.
        if (tick) begin
            nx.acc = sum_low;
            if (carry) begin
                nx.toggle = ~st.toggle;
            end
            // Pulse generator: arm on overflow, go active on the following tick.
            case (st.pulse_state)
                NFS_PULSE_ARMED: begin
                    nx.pulse_state = NFS_PULSE_ACTIVE;
                    nx.pulse_left = width_count;
                end
                NFS_PULSE_ACTIVE: begin
                    if (st.pulse_left <= 8'h01) begin
                        nx.pulse_state = NFS_PULSE_IDLE;
                        nx.pulse_left = 8'h00;
                    end else begin
                        nx.pulse_left = st.pulse_left - 8'h01;
                    end
                end
                default: begin
                    nx.pulse_state = NFS_PULSE_IDLE;
                end
            endcase
            if (carry && st.pulse_mode_sel) begin
                nx.pulse_state = NFS_PULSE_ARMED;
            end
            // Delayed increment load, counted in oscillator ticks.
            if (st.load_wait != 2'h0) begin
                nx.load_wait = st.load_wait - 2'h1;
                if (st.load_wait == 2'h1) begin
                    nx.step_buf = st.step;
                end
            end
        end
        // Overflow flag: a new event wins over a clear in the same cycle.
        if (bus_req.wr && bus_req.addr == NFS_OFF_IRQ) begin
            nx.overflow_irq_on = bus_req.wdata[NFS_IRQ_ON_BIT];
            if (!bus_req.wdata[NFS_IRQ_FLAG_BIT]) begin
                nx.overflow_flag = 1'b0;
            end
        end
        if (tick && carry) begin
            nx.overflow_flag = 1'b1;
        end
        if (ctl_write && st.overflow_irq_on
            && bus_req.wdata[NFS_CTL_INVERT_BIT] != st.output_invert) begin
            nx.overflow_flag = 1'b1;
        end
        // Control register; the level bit is read-only.
        if (ctl_write) begin
            nx.module_on = bus_req.wdata[NFS_CTL_ON_BIT];
            nx.pin_drive_on = bus_req.wdata[NFS_CTL_PIN_BIT];
            nx.output_invert = bus_req.wdata[NFS_CTL_INVERT_BIT];
            nx.pulse_mode_sel = bus_req.wdata[NFS_CTL_PULSE_BIT];
        end
        if (clk_write) begin
            nx.pulse_width_sel = bus_req.wdata[NFS_CLK_WIDTH_LSB +: 3];
            nx.clock_source_sel = nfs_src_type'(bus_req.wdata[NFS_CLK_SOURCE_LSB +: 2]);
        end
        // Accumulator byte writes override only the written byte of a same-cycle addition.
        if (acc_write) begin
            if (bus_req.addr == NFS_OFF_ACC_LOW) begin
                nx.acc[7:0] = bus_req.wdata;
            end else if (bus_req.addr == NFS_OFF_ACC_HIGH) begin
                nx.acc[15:8] = bus_req.wdata;
            end else begin
                nx.acc[19:16] = bus_req.wdata[3:0];
            end
        end
        // Increment registers and their hidden buffers.
        if (step_write) begin
            if (step_low_write) begin
                nx.step[7:0] = bus_req.wdata;
            end else begin
                nx.step[15:8] = bus_req.wdata;
            end
            if (!st.module_on) begin
                nx.step_buf = nx.step;
                nx.load_wait = 2'h0;
            end else if (step_low_write) begin
                nx.load_wait = NFS_STEP_LOAD_TICKS;
            end
        end
        // Final polarity stage, registered so status and pin agree.
        nx.output_level = nfs_raw(nx) ^ nx.output_invert;
        nx.fast_hold = nx.module_on && nx.clock_source_sel == NFS_SRC_FAST;
        // Read data, valid in the cycle after the read strobe.
        nx.rdata = NFS_UNMAPPED_READ;
        if (bus_req.rd && bus_req.addr == NFS_OFF_CONTROL) begin
            nx.rdata = {st.module_on, st.pin_drive_on, st.output_level,
                        st.output_invert, 3'h0, st.pulse_mode_sel};
        end else if (bus_req.rd && bus_req.addr == NFS_OFF_CLOCK_SELECT) begin
            nx.rdata = {st.pulse_width_sel, 3'h0, st.clock_source_sel};
        end else if (bus_req.rd && bus_req.addr == NFS_OFF_ACC_LOW) begin
            nx.rdata = st.acc[7:0];
        end else if (bus_req.rd && bus_req.addr == NFS_OFF_ACC_HIGH) begin
            nx.rdata = st.acc[15:8];
        end else if (bus_req.rd && bus_req.addr == NFS_OFF_ACC_UPPER) begin
            nx.rdata = {4'h0, st.acc[19:16]};
        end else if (bus_req.rd && bus_req.addr == NFS_OFF_STEP_LOW) begin
            nx.rdata = st.step[7:0];
        end else if (bus_req.rd && bus_req.addr == NFS_OFF_STEP_HIGH) begin
            nx.rdata = st.step[15:8];
        end else if (bus_req.rd && bus_req.addr == NFS_OFF_IRQ) begin
            nx.rdata = {6'h00, st.overflow_irq_on, st.overflow_flag};
        end
    end

    // State register; reset clears every field.
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= NFS_STATE_RESET;
        end else begin
            st <= nx;
        end
    end

    // Outputs.
    assign rd_data = st.rdata;
    assign synth_out = st.output_level;
    assign synth_pin_out = st.output_level & st.pin_drive_on;
    assign synth_pin_oe = st.pin_drive_on;
    assign fast_osc_hold = st.fast_hold;
    assign irq_req = st.overflow_flag & st.overflow_irq_on & st.module_on
                     & peripheral_irq_on & global_irq_on;

    a_acc_adds: assert property (@(posedge clk) disable iff (reset)
        (tick && !acc_write) |=> st.acc == $past(sum_low))
        else $error("Accumulator did not take the sum on a tick.");

    a_carry_flag: assert property (@(posedge clk) disable iff (reset)
        (tick && carry) |=> st.overflow_flag)
        else $error("Overflow did not set the flag.");

    a_fdc_toggle: assert property (@(posedge clk) disable iff (reset)
        (tick && carry) |=> st.toggle != $past(st.toggle))
        else $error("Overflow did not toggle the fixed-duty output.");

    a_pulse_starts: assert property (@(posedge clk) disable iff (reset)
        (tick && carry && st.pulse_mode_sel && !ctl_write)
        ##1 (tick && st.pulse_state == NFS_PULSE_ARMED && !carry)
        |=> (st.pulse_state == NFS_PULSE_ACTIVE && st.pulse_left == $past(width_count)))
        else $error("Pulse did not start on the tick after overflow.");

    a_polarity_stage: assert property (@(posedge clk) disable iff (reset)
        st.output_level == (raw_level ^ st.output_invert))
        else $error("Output level does not match raw level and polarity.");

    a_load_when_off: assert property (@(posedge clk) disable iff (reset)
        (step_write && !st.module_on) |=> st.step_buf == st.step)
        else $error("Increment buffer not loaded at once while off.");

    a_load_second_tick: assert property (@(posedge clk) disable iff (reset)
        (step_low_write && st.module_on && !ctl_write) |=> st.load_wait == 2'h2)
        else $error("Low increment write did not start the load delay.");

    a_irq_gated: assert property (@(posedge clk) disable iff (reset)
        irq_req |-> (st.module_on && st.overflow_irq_on && st.overflow_flag))
        else $error("Interrupt request without all enables.");

    a_status_read: assert property (@(posedge clk) disable iff (reset)
        (bus_req.rd && bus_req.addr == NFS_OFF_CONTROL)
        |=> rd_data[NFS_CTL_LEVEL_BIT] == $past(st.output_level))
        else $error("Status bit does not show the output level.");

    // A reset edge leaves every field of the state at zero.
    a_reset_clears: assert property (@(posedge clk)
        reset |=> st == NFS_STATE_RESET)
        else $error("State not cleared by reset.");

    // Hardware only ever sets the flag.
    // Dropping it takes a software write to the interrupt register.
    a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
        (st.overflow_flag && !(bus_req.wr && bus_req.addr == NFS_OFF_IRQ))
        |=> st.overflow_flag)
        else $error("Overflow flag dropped without a write.");

    // Flipping the polarity with the interrupt on flags the new edge.
    // Software sees the resulting output transition as an overflow event.
    a_polarity_flag: assert property (@(posedge clk) disable iff (reset)
        (ctl_write && st.overflow_irq_on
         && bus_req.wdata[NFS_CTL_INVERT_BIT] != st.output_invert) |=> st.overflow_flag)
        else $error("Polarity change did not set the flag.");

    // Without a tick or a byte write the accumulator must not move.
    a_acc_holds: assert property (@(posedge clk) disable iff (reset)
        (!tick && !acc_write) |=> $stable(st.acc))
        else $error("Accumulator moved without a tick.");

    // A carry keeps only the remainder, so the new value lies below the old.
    // This keeps the average frequency exact over many periods.
    a_wrap_keeps: assert property (@(posedge clk) disable iff (reset)
        (tick && carry && !acc_write) |=> st.acc < $past(st.acc))
        else $error("Accumulator did not wrap on overflow.");

    // The delayed load copies the increment registers as they stood.
    a_buf_loads: assert property (@(posedge clk) disable iff (reset)
        (tick && st.load_wait == 2'h1) |=> st.step_buf == $past(st.step))
        else $error("Increment buffer missed its delayed load.");

    // The last active tick of a pulse returns the output to inactive.
    // A carry on that tick re-arms instead, so it is left out here.
    a_pulse_ends: assert property (@(posedge clk) disable iff (reset)
        (tick && !carry && st.pulse_state == NFS_PULSE_ACTIVE && st.pulse_left == 8'h01)
        |=> st.pulse_state == NFS_PULSE_IDLE)
        else $error("Pulse ran past its selected width.");

    // The sleep hold follows the enable and the fast source selection.
    a_hold_follows: assert property (@(posedge clk) disable iff (reset)
        st.fast_hold == (st.module_on && st.clock_source_sel == NFS_SRC_FAST))
        else $error("Fast oscillator hold does not match the setup.");

endmodule // nfs_core

/* pkg/nfs_pkg.sv */
// Package for the numeric frequency synthesiser: register map, field positions,
// reset values, clock source and pulse state encodings and the state carriers.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
package nfs_pkg;

    // Register bus widths and register offsets.
    localparam int NFS_ADDR_W = 3;
    localparam int NFS_DATA_W = 8;
    localparam logic [2:0] NFS_OFF_CONTROL = 3'h0;
    localparam logic [2:0] NFS_OFF_CLOCK_SELECT = 3'h1;
    localparam logic [2:0] NFS_OFF_ACC_LOW = 3'h2;
    localparam logic [2:0] NFS_OFF_ACC_HIGH = 3'h3;
    localparam logic [2:0] NFS_OFF_ACC_UPPER = 3'h4;
    localparam logic [2:0] NFS_OFF_STEP_LOW = 3'h5;
    localparam logic [2:0] NFS_OFF_STEP_HIGH = 3'h6;
    localparam logic [2:0] NFS_OFF_IRQ = 3'h7;

    // Field positions inside the control, clock select and interrupt registers.
    localparam int NFS_CTL_ON_BIT = 7;
    localparam int NFS_CTL_PIN_BIT = 6;
    localparam int NFS_CTL_LEVEL_BIT = 5;
    localparam int NFS_CTL_INVERT_BIT = 4;
    localparam int NFS_CTL_PULSE_BIT = 0;
    localparam int NFS_CLK_WIDTH_LSB = 5;
    localparam int NFS_CLK_SOURCE_LSB = 0;
    localparam int NFS_IRQ_FLAG_BIT = 0;
    localparam int NFS_IRQ_ON_BIT = 1;

    // Datapath widths and the increment load delay in oscillator ticks.
    localparam int NFS_ACC_W = 20;
    localparam int NFS_STEP_W = 16;
    localparam logic [1:0] NFS_STEP_LOAD_TICKS = 2'h2;
    localparam logic [7:0] NFS_UNMAPPED_READ = 8'h00;

    // Accumulator clock source codes.
    typedef enum logic [1:0] {
        NFS_SRC_FAST = 2'b00,
        NFS_SRC_SYS = 2'b01,
        NFS_SRC_CELL = 2'b10,
        NFS_SRC_PIN = 2'b11
    } nfs_src_type;

    // Pulse generator states for pulse-frequency mode.
    typedef enum logic [1:0] {
        NFS_PULSE_IDLE = 2'b00,
        NFS_PULSE_ARMED = 2'b01,
        NFS_PULSE_ACTIVE = 2'b10
    } nfs_pulse_type;

    // One register bus request.
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } nfs_bus_req_type;

    // Whole state of the synthesiser core.
    typedef struct packed {
        logic module_on;
        logic pin_drive_on;
        logic output_invert;
        logic pulse_mode_sel;
        logic [2:0] pulse_width_sel;
        nfs_src_type clock_source_sel;
        logic [19:0] acc;
        logic [15:0] step;
        logic [15:0] step_buf;
        logic [1:0] load_wait;
        logic toggle;
        nfs_pulse_type pulse_state;
        logic [7:0] pulse_left;
        logic output_level;
        logic overflow_flag;
        logic overflow_irq_on;
        logic fast_hold;
        logic [7:0] rdata;
    } nfs_state_type;

    // Whole state of the tick selector: last seen levels of the slow sources.
    typedef struct packed {
        logic fast_prev;
        logic cell_prev;
        logic pin_prev;
    } nfs_tick_state_type;

    localparam nfs_state_type NFS_STATE_RESET = '0;
    localparam nfs_tick_state_type NFS_TICK_RESET = '0;

endpackage

/* core/nfs_tick_sel.sv */
// Accumulator clock selector: turns the chosen source into one-cycle ticks.
// Assumes every source level is synchronous to clk and slower than clk / 2.
`timescale 1ns/10ps
module nfs_tick_sel
    import nfs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Selection and gating.
    input wire nfs_src_type source_sel,
    input wire logic enable,
    // Candidate sources.
    input wire logic fast_internal_osc,
    input wire logic logic_cell_one_out,
    input wire logic clock_pin,
    // One-cycle tick per rising edge of the chosen source.
    output logic tick
);

    nfs_tick_state_type st;
    nfs_tick_state_type nx;
    logic rise;

    // Edge detect on the selected source; the system clock ticks every cycle.
    always_comb begin
        nx.fast_prev = fast_internal_osc;
        nx.cell_prev = logic_cell_one_out;
        nx.pin_prev = clock_pin;
        case (source_sel)
            NFS_SRC_FAST: rise = fast_internal_osc & ~st.fast_prev;
            NFS_SRC_SYS: rise = 1'b1;
            NFS_SRC_CELL: rise = logic_cell_one_out & ~st.cell_prev;
            default: rise = clock_pin & ~st.pin_prev;
        endcase
        tick = enable & rise;
    end

    // State register.
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= NFS_TICK_RESET;
        end else begin
            st <= nx;
        end
    end

    a_sys_ticks: assert property (@(posedge clk) disable iff (reset)
        (enable && source_sel == NFS_SRC_SYS) |-> tick)
        else $error("System clock source did not tick every cycle.");

    a_pin_edge: assert property (@(posedge clk) disable iff (reset)
        (enable && source_sel == NFS_SRC_PIN && $rose(clock_pin)) |-> tick)
        else $error("Rising pin edge produced no tick.");

    a_off_silent: assert property (@(posedge clk) disable iff (reset)
        !enable |-> !tick)
        else $error("Tick seen while the module is off.");

endmodule // nfs_tick_sel

/* sim/nfs_far_model.sv */
// Far-side model: drives the slow clock sources that feed the synthesiser.
// Assumes the bench clock and a synchronous active-high reset.
`timescale 1ns/10ps
module nfs_far_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Source control from the bench.
    input wire logic [1:0] run,
    input wire logic pin_load,
    input wire logic [3:0] pin_edges,
    // Source levels, a quarter of the clock rate at most.
    output logic fast_internal_osc,
    output logic logic_cell_one_out,
    output logic clock_pin
);
    logic [1:0] phase_reg;
    logic [3:0] left_reg;

    // Free phase counter and the number of pin edges still to send.
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_reg <= 2'h0;
            left_reg <= 4'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            if (pin_load) begin
                left_reg <= pin_edges;
            end else if (phase_reg == 2'h3 && left_reg != 4'h0) begin
                left_reg <= left_reg - 4'h1;
            end
        end
    end

    // Sources rest low outside bursts, so each burst unit gives exactly one rising edge.
    assign fast_internal_osc = run[0] & phase_reg[1];
    assign logic_cell_one_out = run[1] & phase_reg[1];
    assign clock_pin = (left_reg != 4'h0) & phase_reg[1];
endmodule // nfs_far_model

/* sim/nfs_core_tb_top.sv */
// Self-checking bench for the synthesiser core through its register port.
// Assumes the package, the core and the far-side model are compiled first.
`timescale 1ns/10ps
module nfs_core_tb_top
    import nfs_pkg::*;
;
    logic clk;
    logic reset;
    nfs_bus_req_type req;
    logic [7:0] rd_data;
    logic synth_out, synth_pin_out, synth_pin_oe, irq_req, fast_osc_hold;
    logic periph_on, glob_on, pin_load, fast_osc, cell_out, clk_pin;
    logic [1:0] run;
    logic [3:0] pin_edges;
    logic [7:0] rv;
    int errors, checks_done, cycles, n;

    nfs_core nfs_core_inst (.clk(clk), .reset(reset), .bus_req(req), .rd_data(rd_data),
        .fast_internal_osc(fast_osc), .logic_cell_one_out(cell_out), .clock_pin(clk_pin),
        .peripheral_irq_on(periph_on), .global_irq_on(glob_on), .synth_out(synth_out),
        .synth_pin_out(synth_pin_out), .synth_pin_oe(synth_pin_oe), .irq_req(irq_req),
        .fast_osc_hold(fast_osc_hold));
    nfs_far_model nfs_far_model_inst (.clk(clk), .reset(reset), .run(run),
        .pin_load(pin_load), .pin_edges(pin_edges), .fast_internal_osc(fast_osc),
        .logic_cell_one_out(cell_out), .clock_pin(clk_pin));

    // Clock of 40 ns period.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Cuts a hung run short well above the expected length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // One-cycle read strobe; data stand only in the following cycle.
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        rd(a, rv);
        chk({24'h0, rv}, {24'h0, e});
    endtask

    // Waits, bounded, until the output shows the given level.
    task automatic till(input logic lv);
        int g;
        g = 0;
        while (synth_out !== lv && g < 400) begin
            @(posedge clk);
            #1;
            g++;
        end
    endtask

    // Length of the second whole stretch at the given level, in clocks.
    task automatic span(input logic lv, output int w);
        repeat (2) begin
            till(~lv);
            till(lv);
            w = 0;
            while (synth_out === lv && w < 400) begin
                @(posedge clk);
                #1;
                w++;
            end
        end
    endtask

    // Main sequence.
    initial begin
        req = '0;
        reset = 1'b1;
        periph_on = 1'b0;
        glob_on = 1'b0;
        run = 2'b00;
        pin_load = 1'b0;
        pin_edges = 4'h0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a < 8; a++) rchk(a[2:0], 8'h00);
        $display("test reset values done");
        wr(NFS_OFF_CONTROL, 8'h5f);
        rchk(NFS_OFF_CONTROL, 8'h71);
        chk({31'h0, synth_pin_oe & synth_pin_out}, 32'h1);
        wr(NFS_OFF_CONTROL, 8'h00);
        #1;
        chk({31'h0, synth_pin_oe}, 32'h0);
        wr(NFS_OFF_CLOCK_SELECT, 8'hff);
        rchk(NFS_OFF_CLOCK_SELECT, 8'he3);
        wr(NFS_OFF_ACC_LOW, 8'h5a);
        wr(NFS_OFF_ACC_HIGH, 8'ha5);
        wr(NFS_OFF_ACC_UPPER, 8'hff);
        rchk(NFS_OFF_ACC_LOW, 8'h5a);
        rchk(NFS_OFF_ACC_HIGH, 8'ha5);
        rchk(NFS_OFF_ACC_UPPER, 8'h0f);
        $display("test registers done");
        wr(NFS_OFF_STEP_HIGH, 8'h80);
        wr(NFS_OFF_STEP_LOW, 8'h00);
        rchk(NFS_OFF_STEP_HIGH, 8'h80);
        wr(NFS_OFF_CLOCK_SELECT, 8'h01);
        wr(NFS_OFF_IRQ, 8'h02);
        periph_on <= 1'b1;
        glob_on <= 1'b1;
        wr(NFS_OFF_CONTROL, 8'h80);
        span(1'b1, n);
        chk(n, 32);
        chk({31'h0, irq_req}, 32'h1);
        @(posedge clk);
        glob_on <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq_req}, 32'h0);
        $display("test fixed duty done");
        for (int w = 0; w < 5; w++) begin
            wr(NFS_OFF_CLOCK_SELECT, {w[2:0], 5'h01});
            wr(NFS_OFF_CONTROL, 8'h81);
            span(1'b1, n);
            chk(n, 1 << w);
        end
        wr(NFS_OFF_CONTROL, 8'h91);
        span(1'b0, n);
        chk(n, 16);
        wr(NFS_OFF_CONTROL, 8'h80);
        span(1'b1, n);
        chk(n, 32);
        $display("test pulse mode done");
        wr(NFS_OFF_CONTROL, 8'h00);
        rd(NFS_OFF_ACC_LOW, rv);
        repeat (20) @(posedge clk);
        rchk(NFS_OFF_ACC_LOW, rv);
        wr(NFS_OFF_IRQ, 8'h02);
        rchk(NFS_OFF_IRQ, 8'h02);
        wr(NFS_OFF_CONTROL, 8'h10);
        rchk(NFS_OFF_IRQ, 8'h03);
        $display("test flag done");
        wr(NFS_OFF_CLOCK_SELECT, 8'h03);
        for (int a = 2; a < 5; a++) wr(a[2:0], 8'h00);
        wr(NFS_OFF_CONTROL, 8'h80);
        wr(NFS_OFF_STEP_HIGH, 8'h00);
        wr(NFS_OFF_STEP_LOW, 8'h01);
        pin_load <= 1'b1;
        pin_edges <= 4'h3;
        @(posedge clk);
        pin_load <= 1'b0;
        repeat (20) @(posedge clk);
        rchk(NFS_OFF_ACC_LOW, 8'h01);
        rchk(NFS_OFF_ACC_HIGH, 8'h00);
        rchk(NFS_OFF_ACC_UPPER, 8'h01);
        $display("test delayed load done");
        for (int s = 0; s < 3; s += 2) begin
            wr(NFS_OFF_CONTROL, 8'h00);
            wr(NFS_OFF_ACC_LOW, 8'h00);
            wr(NFS_OFF_CLOCK_SELECT, {6'h00, s[1:0]});
            wr(NFS_OFF_CONTROL, 8'h80);
            run <= s[1] ? 2'b10 : 2'b01;
            repeat (40) @(posedge clk);
            run <= 2'b00;
            #1;
            chk({31'h0, fast_osc_hold}, {31'h0, s == 0});
            rd(NFS_OFF_ACC_LOW, rv);
            chk({31'h0, rv != 8'h00}, 32'h1);
        end
        $display("test sources done");
        conclude();
    end
endmodule // nfs_core_tb_top
